// File: mpmc_pkg.sv
// package for the modem module power and mode controller (host side)
// assumes a 100 MHz system clock; all pulse widths are counted in milliseconds
package mpmc_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int MS_W = 14;
  localparam logic [MS_W-1:0] SUPPLY_SETTLE_MS = 14'h001E;
  localparam logic [MS_W-1:0] KEY_ON_MS = 14'h01F4;
  localparam logic [MS_W-1:0] KEY_OFF_MS = 14'h028A;
  localparam logic [MS_W-1:0] RESTART_MS = 14'h012C;
  localparam logic [MS_W-1:0] LOGOUT_MS = 14'h2EE0;

  // ==========================================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_UNPOWERED = 4'h0,
    ST_SETTLE = 4'h1,
    ST_OFF = 4'h2,
    ST_KEY_ON = 4'h3,
    ST_ON = 4'h4,
    ST_KEY_OFF = 4'h5,
    ST_LOGOUT = 4'h6,
    ST_RESTART = 4'h7,
    ST_SW_DOWN = 4'h8
  } mpmc_state_t;

  // how the module is attached, which decides the sleep and wake method
  typedef enum logic [1:0] {
    LINK_UART = 2'h0,
    LINK_USB_REMOTE_WAKE = 2'h1,
    LINK_USB_RING_WAKE = 2'h2,
    LINK_USB_NO_SUSPEND = 2'h3
  } mpmc_link_t;

  // one-cycle command pulses from the user side
  typedef struct packed {
    logic power_on;
    logic power_off;
    logic sw_down;
    logic restart;
    logic cut_power;
  } mpmc_cmd_t;

  // status returned to the user side
  typedef struct packed {
    mpmc_state_t state;
    logic module_on;
    logic busy;
    logic key_held_low;
  } mpmc_status_t;

endpackage : mpmc_pkg

// File: mpmc_ctrl.sv
// host-side sequencer for a cellular modem module: supply, power key, restart,
// sleep permission, wake, bus power and airplane pin
// assumes open-drain buffers outside for the key and restart lines, and a
// supply switch driven by supply_en
//
// Contract
// - Key held low at least 500 ms while module off starts turn-on.
// - Key held low at least 650 ms then released requests turn-off.
// - After turn-off, wait 12 s before cutting power or restarting.
// - Restart line held low at least 300 ms, release triggers reset.
// - Wait at least 30 ms after supply rises before pulling key low.
// - After software power-down command keep key line high.
// - Remove module power only after module has been shut down.
// - UART sleep needs permit, terminal-ready high, bus power sense low.
// - UART host drives terminal-ready low to wake the module.
// - USB sleep needs permit, terminal-ready high, bus in suspend.
// - Without remote wakeup, module wakes host by ring indicator.
// - Without suspend, host removes bus power to sleep, restores to wake.
// - Key may be tied low permanently for automatic power-on.
`timescale 1ns/1ps
`default_nettype none

module mpmc_ctrl #(
  parameter int CYC_PER_MS = mpmc_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user command port
  input wire mpmc_pkg::mpmc_cmd_t cmd,
  input wire mpmc_pkg::mpmc_link_t link_mode,
  input wire logic sleep_allow,
  input wire logic wake_req,
  input wire logic airplane_req,
  output mpmc_pkg::mpmc_status_t status,
  output logic cmd_refused,
  output logic host_wake_event,
  output logic usb_suspend_req,
  // module supply switch
  output logic supply_en,
  // power key line, open drain
  input wire logic power_key_line_i,
  output logic power_key_line_o,
  output logic power_key_line_oe,
  // restart line, open drain
  input wire logic restart_line_i,
  output logic restart_line_o,
  output logic restart_line_oe,
  // sleep and wake pins
  output logic term_ready,
  output logic usb_bus_power_en,
  input wire logic ring_indicator_output,
  // airplane control pin, active low
  output logic radio_disable_n
);
  import mpmc_pkg::*;

  localparam int DIV_W = $clog2(CYC_PER_MS);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);

  mpmc_state_t state;
  logic entering;
  logic [DIV_W-1:0] div;
  logic ms_tick;
  logic [MS_W-1:0] ms_cnt;
  logic key_s1, key_s2;
  logic rst_s1, rst_s2;
  logic ri_s1, ri_s2, ri_prev;
  logic accepted;

  // ==========================================================================
  // millisecond timebase
  // divider restarts on every state entry so each interval is whole ms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else if (entering || ms_tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  assign ms_tick = (div == DIV_LAST);

  // elapsed ms in the current state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
    end else if (entering) begin
      ms_cnt <= '0;
    end else if (ms_tick && ms_cnt != {MS_W{1'b1}}) begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // pin synchronisers
  // the first stage feeds only the second; nothing else looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_s1 <= 1'b1;
      key_s2 <= 1'b1;
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
      ri_s1 <= 1'b1;
      ri_s2 <= 1'b1;
      ri_prev <= 1'b1;
    end else begin
      key_s1 <= power_key_line_i;
      key_s2 <= key_s1;
      rst_s1 <= restart_line_i;
      rst_s2 <= rst_s1;
      ri_s1 <= ring_indicator_output;
      ri_s2 <= ri_s1;
      ri_prev <= ri_s2;
    end
  end

  // ==========================================================================
  // power sequencer
  // one command at a time; anything that arrives mid-sequence is refused
  always_comb begin
    entering = 1'b0;
    accepted = 1'b0;
    case (state)
      ST_UNPOWERED: accepted = cmd.power_on;
      ST_SETTLE: entering = (ms_cnt == SUPPLY_SETTLE_MS);
      ST_OFF: accepted = cmd.power_on | cmd.cut_power;
      ST_KEY_ON: entering = (ms_cnt == KEY_ON_MS);
      ST_ON: accepted = cmd.power_off | cmd.sw_down | cmd.restart;
      ST_KEY_OFF: entering = (ms_cnt == KEY_OFF_MS);
      ST_LOGOUT: entering = (ms_cnt == LOGOUT_MS);
      ST_RESTART: entering = (ms_cnt == RESTART_MS);
      ST_SW_DOWN: entering = (ms_cnt == LOGOUT_MS);
      default: entering = 1'b1;
    endcase
    if (accepted) begin
      entering = 1'b1;
    end
  end

  // state register; priority power_off over sw_down over restart in ST_ON
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_UNPOWERED;
    end else begin
      case (state)
        ST_UNPOWERED: begin
          if (cmd.power_on) state <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (ms_cnt == SUPPLY_SETTLE_MS) state <= ST_KEY_ON;
        end
        ST_OFF: begin
          if (cmd.cut_power) state <= ST_UNPOWERED;
          else if (cmd.power_on) state <= ST_KEY_ON;
        end
        ST_KEY_ON: begin
          if (ms_cnt == KEY_ON_MS) state <= ST_ON;
        end
        ST_ON: begin
          if (cmd.power_off) state <= ST_KEY_OFF;
          else if (cmd.sw_down) state <= ST_SW_DOWN;
          else if (cmd.restart) state <= ST_RESTART;
        end
        ST_KEY_OFF: begin
          if (ms_cnt == KEY_OFF_MS) state <= ST_LOGOUT;
        end
        ST_LOGOUT: begin
          if (ms_cnt == LOGOUT_MS) state <= ST_OFF;
        end
        ST_RESTART: begin
          if (ms_cnt == RESTART_MS) state <= ST_ON;
        end
        ST_SW_DOWN: begin
          if (ms_cnt == LOGOUT_MS) state <= ST_OFF;
        end
        default: state <= ST_UNPOWERED;
      endcase
    end
  end

  // ==========================================================================
  // pin drivers
  // key and restart only ever pull low; released means oe low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_en <= 1'b0;
      power_key_line_oe <= 1'b0;
      restart_line_oe <= 1'b0;
    end else begin
      supply_en <= (state != ST_UNPOWERED) || cmd.power_on;
      power_key_line_oe <= (state == ST_SETTLE && ms_cnt == SUPPLY_SETTLE_MS)
        || (state == ST_OFF && cmd.power_on && !cmd.cut_power)
        || (state == ST_KEY_ON && ms_cnt != KEY_ON_MS)
        || (state == ST_ON && cmd.power_off)
        || (state == ST_KEY_OFF && ms_cnt != KEY_OFF_MS);
      restart_line_oe <= (state == ST_ON && cmd.restart && !cmd.power_off
        && !cmd.sw_down) || (state == ST_RESTART && ms_cnt != RESTART_MS);
    end
  end

  assign power_key_line_o = 1'b0;
  assign restart_line_o = 1'b0;

  // ==========================================================================
  // sleep, wake and airplane control
  // wake_req overrides permission so the module wakes even with sleep allowed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_ready <= 1'b0;
      usb_bus_power_en <= 1'b0;
      usb_suspend_req <= 1'b0;
      radio_disable_n <= 1'b1;
    end else begin
      term_ready <= sleep_allow && !wake_req;
      case (link_mode)
        LINK_UART: usb_bus_power_en <= 1'b0;
        LINK_USB_NO_SUSPEND: usb_bus_power_en <= !(sleep_allow && !wake_req);
        default: usb_bus_power_en <= 1'b1;
      endcase
      usb_suspend_req <= (link_mode == LINK_USB_REMOTE_WAKE
        || link_mode == LINK_USB_RING_WAKE) && sleep_allow && !wake_req;
      radio_disable_n <= !airplane_req;
    end
  end

  // ring falling edge wakes the host when the link relies on it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_wake_event <= 1'b0;
    end else begin
      host_wake_event <= ri_prev && !ri_s2
        && (link_mode == LINK_UART || link_mode == LINK_USB_RING_WAKE);
    end
  end

  // ==========================================================================
  // status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_refused <= 1'b0;
    end else begin
      cmd_refused <= (|cmd) && !accepted;
    end
  end

  // the key input also shows a key tied low on the board
  // one driver for the whole word keeps the status port a single assignment
  assign status = '{
    state: state,
    module_on: (state == ST_ON),
    busy: (state != ST_ON && state != ST_OFF && state != ST_UNPOWERED),
    key_held_low: (!key_s2 || !rst_s2)
  };

  // ==========================================================================
  // checks
  AST_KEY_ON_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == ST_KEY_ON && state == ST_ON) |-> $past(ms_cnt) == KEY_ON_MS)
    else $error("turn-on key pulse shorter than 500 ms");
  AST_KEY_OFF_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == ST_KEY_OFF && state == ST_LOGOUT) |-> !power_key_line_oe
    && $past(ms_cnt) == KEY_OFF_MS)
    else $error("turn-off key pulse not 650 ms then released");
  AST_LOGOUT_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == ST_LOGOUT && state == ST_OFF) |-> $past(ms_cnt) == LOGOUT_MS)
    else $error("logout wait not 12 s");
  AST_RESTART_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(restart_line_oe) |-> $past(ms_cnt) == RESTART_MS && state == ST_ON)
    else $error("restart pulse not 300 ms");
  AST_SETTLE: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(power_key_line_oe) && $past(state) == ST_SETTLE)
    |-> $past(ms_cnt) == SUPPLY_SETTLE_MS)
    else $error("key pulled before supply settled");
  AST_SW_DOWN_KEY: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_SW_DOWN |-> !power_key_line_oe)
    else $error("key pulled during software power-down");
  AST_SUPPLY_CUT: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(supply_en) |-> $past(state, 2) == ST_OFF)
    else $error("supply removed while module not shut down");
  AST_UART_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (link_mode == LINK_UART && $stable(link_mode)) |=> !usb_bus_power_en)
    else $error("bus power present in uart sleep set-up");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    wake_req |=> !term_ready && !usb_suspend_req)
    else $error("wake request did not drop terminal-ready");
  AST_RING: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(ri_s2) && link_mode == LINK_USB_RING_WAKE) |=> host_wake_event)
    else $error("ring edge did not wake host");
  AST_RELEASED: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_ON && $past(state) == ST_ON) |-> !power_key_line_oe && !restart_line_oe)
    else $error("line held low between pulses");

endmodule : mpmc_ctrl

`default_nettype wire

// File: mpmc_modem_model.sv
// behavioural cellular modem module as seen at its control pins
// assumes key and restart lines arrive already resolved, pull-up included
`timescale 1ns/1ps
`default_nettype none

module mpmc_modem_model #(
  parameter int CYC_PER_MS = 2,
  parameter bit AIR_CFG = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins from the host
  input wire logic supply,
  input wire logic key_n,
  input wire logic restart_n,
  input wire logic dtr,
  input wire logic vbus,
  input wire logic radio_off_n,
  // bench stimulus standing in for commands and reports
  input wire logic pwd_cmd,
  input wire logic report,
  // toward the host
  output logic ring_n,
  output logic on,
  output logic asleep,
  output logic airplane,
  output logic [7:0] resets
);
  // ==========
  // pulse widths
  int key_lo;
  int rst_lo;
  int ring_cnt;

  // key and restart low time counted in cycles; cleared on release edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on <= 1'b0;
      key_lo <= 0;
      rst_lo <= 0;
      resets <= '0;
      ring_cnt <= 0;
    end else begin
      key_lo <= key_n ? 0 : key_lo + 1;
      rst_lo <= restart_n ? 0 : rst_lo + 1;
      ring_cnt <= (report && on) ? 20 : (ring_cnt > 0 ? ring_cnt - 1 : 0);
      if (!supply || pwd_cmd) begin
        on <= 1'b0;
      end else if (!on && key_lo >= 500 * CYC_PER_MS) begin
        on <= 1'b1;
      end else if (on && key_n && key_lo >= 650 * CYC_PER_MS) begin
        on <= 1'b0;
      end
      // baseband restart only, power state kept
      if (restart_n && rst_lo >= 300 * CYC_PER_MS) begin
        resets <= resets + 8'h01;
      end
    end
  end

  // sleep needs terminal-ready high and bus power absent; permit taken as sent
  assign asleep = on && dtr && !vbus;
  assign airplane = AIR_CFG && !radio_off_n;
  assign ring_n = (ring_cnt == 0);
endmodule : mpmc_modem_model

`default_nettype wire

// File: tb.sv
// self-checking bench for the modem power and mode controller
// assumes a shortened millisecond (2 cycles) so the long waits fit the run
`timescale 1ns/1ps
`default_nettype none

module tb;
  import mpmc_pkg::*;
  localparam int C = 2;
  localparam logic [4:0] C_ON = 5'h10;
  localparam logic [4:0] C_OFF = 5'h08;
  localparam logic [4:0] C_SW = 5'h04;
  localparam logic [4:0] C_RST = 5'h02;
  localparam logic [4:0] C_CUT = 5'h01;
  // ==========
  // signals
  logic clk, rst_n, sleep_allow, wake_req, airplane_req, pwd_cmd, report, r;
  logic cmd_refused, host_wake_event, usb_suspend_req, supply_en, pk_o, pk_oe, rs_o, rs_oe;
  logic term_ready, usb_bus_power_en, ring_n, radio_disable_n, key_w, rs_w;
  logic m_on, m_sleep, m_air;
  logic [7:0] m_resets;
  mpmc_cmd_t cmd;
  mpmc_link_t link_mode;
  mpmc_status_t status;
  int failures, n_tests, cyc, seed, n, i, rnd, key_cnt;

  // open-drain lines with pull-up: low only while someone drives
  assign key_w = pk_oe ? pk_o : 1'b1;
  assign rs_w = rs_oe ? rs_o : 1'b1;

  mpmc_ctrl #(.CYC_PER_MS(C)) u_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd),
    .link_mode(link_mode), .sleep_allow(sleep_allow), .wake_req(wake_req),
    .airplane_req(airplane_req), .status(status), .cmd_refused(cmd_refused),
    .host_wake_event(host_wake_event), .usb_suspend_req(usb_suspend_req),
    .supply_en(supply_en), .power_key_line_i(key_w), .power_key_line_o(pk_o),
    .power_key_line_oe(pk_oe), .restart_line_i(rs_w), .restart_line_o(rs_o),
    .restart_line_oe(rs_oe), .term_ready(term_ready), .usb_bus_power_en(usb_bus_power_en),
    .ring_indicator_output(ring_n), .radio_disable_n(radio_disable_n));

  mpmc_modem_model #(.CYC_PER_MS(C)) u_mod (.clk(clk), .rst_n(rst_n), .supply(supply_en),
    .key_n(key_w), .restart_n(rs_w), .dtr(term_ready), .vbus(usb_bus_power_en),
    .radio_off_n(radio_disable_n), .pwd_cmd(pwd_cmd), .report(report), .ring_n(ring_n),
    .on(m_on), .asleep(m_sleep), .airplane(m_air), .resets(m_resets));

  // ==========
  // clock, hang guard, key watcher
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (pk_oe) key_cnt++;
    if (cyc == 70000) begin
      failures++;
      $display("[ERR] %0t run took too long", $time);
      print_verdict();
    end
  end

  // ==========
  // checks and drivers
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %0t width %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic chk_st(input mpmc_state_t got, input mpmc_state_t exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t state got %h exp %h", $time, got, exp);
    end
  endtask : chk_st
  function automatic logic exp_vbus(input mpmc_link_t m, input logic s, input logic w);
    return m == LINK_UART ? 1'b0 : (m == LINK_USB_NO_SUSPEND ? !(s && !w) : 1'b1);
  endfunction : exp_vbus
  function automatic logic sig(input int w);
    return w == 0 ? pk_oe : (w == 1 ? rs_oe : status.busy);
  endfunction : sig
  // refusal lands on the first edge after the command; both edges are sampled
  task automatic send(input logic [4:0] c, output logic rf);
    cmd = mpmc_cmd_t'(c);
    @(negedge clk);
    cmd = '0;
    rf = cmd_refused;
    @(negedge clk);
    rf = rf | cmd_refused;
  endtask : send
  task automatic span(input logic lvl, input int w, output int k);
    k = 0;
    while (sig(w) === lvl && k < 30000) begin
      @(negedge clk);
      k++;
    end
  endtask : span
  task automatic power_up;
    int k;
    logic rf;
    send(C_ON, rf);
    span(1'b0, 0, k);
    chk_rng(k, 30 * C - 2, 30 * C + 2);
    span(1'b1, 0, k);
    chk_rng(k, 500 * C, 500 * C + 2);
    @(negedge clk);
    chk_bit(m_on, 1'b1);
    chk_st(status.state, ST_ON);
    chk_bit(status.module_on, 1'b1);
    $display("test power_up done");
  endtask : power_up
  task automatic ring_try(input mpmc_link_t m, input logic exp);
    logic seen;
    link_mode = m;
    report = 1'b1;
    @(negedge clk);
    report = 1'b0;
    seen = 1'b0;
    repeat (40) begin
      @(negedge clk);
      seen = seen | host_wake_event;
    end
    chk_bit(seen, exp);
  endtask : ring_try
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ==========
  // main sequence
  initial begin
    {rst_n, pwd_cmd, report, sleep_allow, airplane_req, wake_req} = '0;
    cmd = '0;
    link_mode = LINK_UART;
    seed = 57;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk_bit(supply_en, 1'b0);
    chk_bit(pk_oe, 1'b0);
    chk_bit(radio_disable_n, 1'b1);
    send(C_OFF, r);
    chk_bit(r, 1'b1);
    power_up();
    send(C_CUT, r);
    chk_bit(r, 1'b1);
    chk_bit(supply_en, 1'b1);
    for (i = 0; i < 200; i++) begin
      rnd = $random(seed);
      {sleep_allow, wake_req, airplane_req} = rnd[2:0];
      link_mode = mpmc_link_t'(rnd[4:3]);
      @(negedge clk);
      chk_bit(term_ready, sleep_allow && !wake_req);
      chk_bit(usb_bus_power_en, exp_vbus(link_mode, sleep_allow, wake_req));
      chk_bit(m_air, airplane_req);
      if (link_mode == LINK_UART) chk_bit(m_sleep, sleep_allow && !wake_req);
      r = (link_mode == LINK_USB_REMOTE_WAKE || link_mode == LINK_USB_RING_WAKE);
      chk_bit(usb_suspend_req, r && sleep_allow && !wake_req);
      chk_bit(status.key_held_low, 1'b0);
      chk_bit(status.module_on, 1'b1);
    end
    {sleep_allow, airplane_req, wake_req} = 3'b001;
    ring_try(LINK_UART, 1'b1);
    ring_try(LINK_USB_REMOTE_WAKE, 1'b0);
    ring_try(LINK_USB_RING_WAKE, 1'b1);
    link_mode = LINK_UART;
    $display("test pins done");
    send(C_RST, r);
    span(1'b1, 1, n);
    chk_rng(n, 300 * C - 1, 300 * C + 2);
    @(negedge clk);
    chk_bit(m_resets == 8'h01, 1'b1);
    chk_bit(m_on, 1'b1);
    send(C_OFF, r);
    chk_bit(r, 1'b0);
    @(negedge clk);
    chk_bit(status.key_held_low, 1'b1);
    span(1'b1, 0, n);
    chk_rng(n + 1, 650 * C - 1, 650 * C + 2);
    send(C_ON, r);
    chk_bit(r, 1'b1);
    chk_bit(m_on, 1'b0);
    span(1'b1, 2, n);
    chk_rng(n, 12000 * C - 4, 12000 * C + 2);
    chk_st(status.state, ST_OFF);
    send(C_CUT, r);
    chk_bit(supply_en, 1'b0);
    chk_st(status.state, ST_UNPOWERED);
    $display("test restart_off done");
    power_up();
    pwd_cmd = 1'b1;
    send(C_SW, r);
    pwd_cmd = 1'b0;
    chk_bit(r, 1'b0);
    rnd = key_cnt;
    span(1'b1, 2, n);
    chk_rng(n, 12000 * C - 2, 12000 * C + 2);
    chk_bit(key_cnt == rnd, 1'b1);
    chk_bit(m_on, 1'b0);
    chk_st(status.state, ST_OFF);
    $display("test sw_down done");
    send(C_ON, r);
    chk_bit(r, 1'b0);
    span(1'b1, 0, n);
    chk_rng(n, 500 * C - 1, 500 * C + 2);
    chk_bit(m_on, 1'b1);
    $display("test on_from_off done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
